// ### supervisor_pkg.sv
// Operation
// - Reset held through undervoltage, then 250 ms
// - Strap picks watchdog period 150/600/1200 ms
// - Manual input ignores lows under 1 ms
// - Manual low of 1 ms forces reset
// - Tolerance strap picks 5% or 10% comparator
// - Any cause drives both reset outputs
// - Reset stays one active period after cause
// - No kick falling edge within period: reset
// - Low reset output is open drain
// - Kick falling edge restarts watchdog while reset is released; kicks during reset are ignored
package supervisor_pkg;

    localparam int CLK_FREQ_KHZ = 250000;

    localparam int RESET_ACTIVE_MS = 250;
    localparam int WDT_SHORT_MS = 150;
    localparam int WDT_MID_MS = 600;
    localparam int WDT_LONG_MS = 1200;
    localparam int DEBOUNCE_MS = 1;

    localparam int RESET_ACTIVE_CYCLES = RESET_ACTIVE_MS * CLK_FREQ_KHZ;
    localparam int WDT_SHORT_CYCLES = WDT_SHORT_MS * CLK_FREQ_KHZ;
    localparam int WDT_MID_CYCLES = WDT_MID_MS * CLK_FREQ_KHZ;
    localparam int WDT_LONG_CYCLES = WDT_LONG_MS * CLK_FREQ_KHZ;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_FREQ_KHZ;

    localparam int CNT_W = 32;

    // timeout strap encoding, code 3 cannot be strapped
    localparam logic [1:0] TSEL_TIED_LOW = 2'h0;
    localparam logic [1:0] TSEL_OPEN = 2'h1;
    localparam logic [1:0] TSEL_TIED_HIGH = 2'h2;

    // pin positions in the synchroniser vector
    localparam int PIN_MANUAL = 0;
    localparam int PIN_KICK = 1;
    localparam int PIN_BELOW_5 = 2;
    localparam int PIN_BELOW_10 = 3;
    localparam int PIN_TOLERANCE = 4;
    localparam int PIN_TSEL_LO = 5;
    localparam int PIN_TSEL_HI = 6;
    localparam int PIN_COUNT = 7;

    localparam logic [PIN_COUNT-1:0] PINS_RESET = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;

    typedef enum logic [2:0] {
        SUP_HOLD = 3'h1,
        SUP_STRETCH = 3'h2,
        SUP_RUN = 3'h4
    } sup_state_e;

endpackage

// ### manual_reset_filter.sv
`timescale 1ns/1ps
module manual_reset_filter #(
    parameter int FILTER_CYCLES = supervisor_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // synchronised level, high while the input is pulled low
    input wire logic pin_low,
    // debounced press
    output logic pressed
);
    import supervisor_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic pressed;
    } filt_s;

    localparam filt_s FILT_RESET = '{count: CNT_ZERO, pressed: 1'b0};
    localparam logic [CNT_W-1:0] LAST = CNT_W'(FILTER_CYCLES - 1);

    filt_s regs;
    filt_s next_regs;

    // a press must stand a full filter time; release ends it at once
    always_comb begin
        next_regs = regs;
        if (!pin_low) begin
            next_regs.count = CNT_ZERO;
            next_regs.pressed = 1'b0;
        end else if (regs.count >= LAST) begin
            next_regs.pressed = 1'b1;
        end else begin
            next_regs.count = regs.count + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regs <= FILT_RESET;
        end else begin
            regs <= next_regs;
        end
    end

    assign pressed = regs.pressed;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_press_after_filter: assert property ($rose(regs.pressed) |-> $past(regs.count) == LAST)
        else $error("press accepted before the filter time");
    a_release_drops: assert property (!pin_low |=> !regs.pressed && regs.count == CNT_ZERO)
        else $error("press not dropped on release");

endmodule

// ### supervisor_watchdog_reset.sv
`timescale 1ns/1ps
module supervisor_watchdog_reset #(
    parameter int RESET_ACTIVE_CYCLES = supervisor_pkg::RESET_ACTIVE_CYCLES,
    parameter int WDT_SHORT_CYCLES = supervisor_pkg::WDT_SHORT_CYCLES,
    parameter int WDT_MID_CYCLES = supervisor_pkg::WDT_MID_CYCLES,
    parameter int WDT_LONG_CYCLES = supervisor_pkg::WDT_LONG_CYCLES,
    parameter int DEBOUNCE_CYCLES = supervisor_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // supply comparator results, high while supply is under that threshold
    input wire logic supply_below_5pct,
    input wire logic supply_below_10pct,
    // straps
    input wire logic tolerance_select,
    input wire logic [1:0] timeout_select,
    // processor side
    input wire logic manual_reset_n,
    input wire logic watchdog_kick_n,
    output logic reset_out_high,
    output logic reset_out_low_n_out,
    output logic reset_out_low_n_oe
);
    import supervisor_pkg::*;

    typedef struct packed {
        logic [PIN_COUNT-1:0] sync1;
        logic [PIN_COUNT-1:0] sync2;
        logic kick_prev;
        sup_state_e state;
        logic [CNT_W-1:0] count;
        logic rst_high;
        logic drive_level;
        logic drive_en;
    } sup_s;

    localparam sup_s SUP_RESET = '{
        sync1: PINS_RESET,
        sync2: PINS_RESET,
        kick_prev: 1'b0,
        state: SUP_HOLD,
        count: CNT_ZERO,
        rst_high: 1'b1,
        drive_level: 1'b0,
        drive_en: 1'b1
    };

    localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_ACTIVE_CYCLES - 1);

    // last count of the watchdog period for a strap code
    function automatic logic [CNT_W-1:0] wdt_last(input logic [1:0] code);
        logic [CNT_W-1:0] last;
        last = CNT_W'(WDT_MID_CYCLES - 1);
        if (code == TSEL_TIED_LOW) begin
            last = CNT_W'(WDT_SHORT_CYCLES - 1);
        end else if (code == TSEL_TIED_HIGH) begin
            last = CNT_W'(WDT_LONG_CYCLES - 1);
        end
        return last;
    endfunction

    sup_s regs;
    sup_s next_regs;
    logic [PIN_COUNT-1:0] pins;
    logic manual_pressed;
    logic kick_fall;
    logic supply_low;
    logic cause;
    logic [CNT_W-1:0] wdt_limit;

    always_comb begin
        pins = '0;
        pins[PIN_MANUAL] = manual_reset_n;
        pins[PIN_KICK] = watchdog_kick_n;
        pins[PIN_BELOW_5] = supply_below_5pct;
        pins[PIN_BELOW_10] = supply_below_10pct;
        pins[PIN_TOLERANCE] = tolerance_select;
        pins[PIN_TSEL_LO] = timeout_select[0];
        pins[PIN_TSEL_HI] = timeout_select[1];
    end

    manual_reset_filter #(
        .FILTER_CYCLES(DEBOUNCE_CYCLES)
    ) u_manual_reset_filter (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_low(~regs.sync2[PIN_MANUAL]),
        .pressed(manual_pressed)
    );

    // falling edge of the kick; a pulse of a few cycles still counts
    assign kick_fall = regs.kick_prev & ~regs.sync2[PIN_KICK];
    assign supply_low = regs.sync2[PIN_TOLERANCE] ? regs.sync2[PIN_BELOW_10] : regs.sync2[PIN_BELOW_5];
    assign cause = supply_low | manual_pressed;
    assign wdt_limit = wdt_last({regs.sync2[PIN_TSEL_HI], regs.sync2[PIN_TSEL_LO]});

    always_comb begin
        next_regs = regs;
        next_regs.sync1 = pins;
        next_regs.sync2 = regs.sync1;
        next_regs.kick_prev = regs.sync2[PIN_KICK];
        unique case (regs.state)
            SUP_HOLD: begin
                next_regs.count = CNT_ZERO;
                if (!cause) begin
                    next_regs.state = SUP_STRETCH;
                end
            end
            SUP_STRETCH: begin
                if (cause) begin
                    // a fresh cause restarts the whole active period
                    next_regs.state = SUP_HOLD;
                    next_regs.count = CNT_ZERO;
                end else if (regs.count >= RESET_LAST) begin
                    next_regs.state = SUP_RUN;
                    next_regs.count = CNT_ZERO;
                end else begin
                    next_regs.count = regs.count + CNT_ONE;
                end
            end
            SUP_RUN: begin
                if (cause) begin
                    next_regs.state = SUP_HOLD;
                    next_regs.count = CNT_ZERO;
                end else if (kick_fall) begin
                    next_regs.count = CNT_ZERO;
                end else if (regs.count >= wdt_limit) begin
                    // >= so a strap moved to a shorter period still expires
                    next_regs.state = SUP_STRETCH;
                    next_regs.count = CNT_ZERO;
                end else begin
                    next_regs.count = regs.count + CNT_ONE;
                end
            end
            default: begin
                next_regs.state = SUP_HOLD;
                next_regs.count = CNT_ZERO;
            end
        endcase
        next_regs.rst_high = (next_regs.state != SUP_RUN);
        next_regs.drive_level = 1'b0;
        next_regs.drive_en = (next_regs.state != SUP_RUN);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regs <= SUP_RESET;
        end else begin
            regs <= next_regs;
        end
    end

    assign reset_out_high = regs.rst_high;
    assign reset_out_low_n_out = regs.drive_level;
    assign reset_out_low_n_oe = regs.drive_en;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence stretch_end;
        regs.state == SUP_STRETCH && regs.count >= RESET_LAST && !cause;
    endsequence

    sequence wdt_expire;
        regs.state == SUP_RUN && regs.count >= wdt_limit && !kick_fall && !cause;
    endsequence

    a_supply_holds_reset: assert property (supply_low |=> reset_out_high && regs.state == SUP_HOLD)
        else $error("undervoltage did not hold reset");
    a_stretch_release: assert property (stretch_end |=> !reset_out_high ##0 regs.count == CNT_ZERO)
        else $error("reset not released after the active period");
    a_run_entry_timed: assert property ($rose(regs.state == SUP_RUN) |-> $past(regs.count) == RESET_LAST)
        else $error("reset released before a full active period");
    a_wdt_expiry: assert property (wdt_expire |=> reset_out_high ##1 reset_out_high)
        else $error("watchdog expiry did not assert reset");
    a_wdt_period: assert property (regs.state == SUP_RUN |-> regs.count <= wdt_limit)
        else $error("watchdog count past the selected period");
    a_kick_restart: assert property (regs.state == SUP_RUN && kick_fall && !cause |=> regs.count == CNT_ZERO)
        else $error("kick did not restart the watchdog");
    a_wdt_cleared: assert property (regs.state == SUP_HOLD |=> regs.count == CNT_ZERO)
        else $error("watchdog count not cleared in reset");
    a_tolerance_pick: assert property (!regs.sync2[PIN_TOLERANCE] && regs.sync2[PIN_BELOW_5] |=> reset_out_high)
        else $error("5 percent threshold ignored");
    a_manual_reset: assert property (manual_pressed |=> reset_out_high && reset_out_low_n_oe)
        else $error("manual press did not assert reset");
    a_open_drain: assert property (reset_out_low_n_oe == reset_out_high && !reset_out_low_n_out)
        else $error("open drain output misdriven");

endmodule

// ### host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model #(
    parameter int KICK_GAP = 20
) (
    // clock
    input wire logic core_clk,
    // reset line and bench enable
    input wire logic reset_line_n,
    input wire logic kick_en,
    // watchdog strobe
    output logic watchdog_kick_n
);
    int phase = 0;
    initial watchdog_kick_n = 1'b1;
    // two low cycles so the synchroniser cannot miss the edge
    always @(negedge core_clk) begin
        if (!kick_en || reset_line_n !== 1'b1) begin
            phase <= 0;
            watchdog_kick_n <= 1'b1;
        end else begin
            phase <= (phase + 1) % KICK_GAP;
            watchdog_kick_n <= phase >= 2;
        end
    end
endmodule

// ### test_supervisor_watchdog_reset.sv
`timescale 1ns/1ps
module test_supervisor_watchdog_reset;
    localparam int RA = 20;
    localparam int P [3] = '{30, 60, 120};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_below_5pct = 1'b0;
    logic supply_below_10pct = 1'b0;
    logic tolerance_select = 1'b0;
    logic [1:0] timeout_select = 2'h0;
    logic manual_reset_n = 1'b1;
    logic kick_en = 1'b0;
    logic watchdog_kick_n;
    logic reset_out_high;
    logic reset_out_low_n_out;
    logic reset_out_low_n_oe;
    // pull-up on the open-drain line
    wire reset_line_n = reset_out_low_n_oe ? reset_out_low_n_out : 1'b1;
    int n_fail = 0;
    int samples_checked = 0;
    int n;

`define CHK(nm, e, a) begin samples_checked++; if ((e) !== (a)) begin n_fail++; \
$display("ERROR %s expected %0h seen %0h", nm, e, a); end end

    supervisor_watchdog_reset #(.RESET_ACTIVE_CYCLES(RA), .WDT_SHORT_CYCLES(30), .WDT_MID_CYCLES(60),
        .WDT_LONG_CYCLES(120), .DEBOUNCE_CYCLES(5)) u_supervisor_watchdog_reset (
        .core_clk(core_clk), .sys_rst(sys_rst), .supply_below_5pct(supply_below_5pct),
        .supply_below_10pct(supply_below_10pct), .tolerance_select(tolerance_select),
        .timeout_select(timeout_select), .manual_reset_n(manual_reset_n), .watchdog_kick_n(watchdog_kick_n),
        .reset_out_high(reset_out_high), .reset_out_low_n_out(reset_out_low_n_out),
        .reset_out_low_n_oe(reset_out_low_n_oe));

    host_cpu_model u_host_cpu_model (.core_clk(core_clk), .reset_line_n(reset_line_n), .kick_en(kick_en),
        .watchdog_kick_n(watchdog_kick_n));

    initial forever #2 core_clk = ~core_clk;

    task automatic wait_rst(input logic v, output int cnt);
        cnt = 0;
        while (reset_out_high !== v && cnt < 2000) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask

    task automatic in_range(input string nm, input int v, input int lo, input int hi);
        `CHK(nm, 1'b1, (v >= lo && v <= hi))
    endtask

    // counts cycles with reset asserted over a span; unknown counts as asserted
    task automatic quiet(input int cyc, output int hi);
        hi = 0;
        repeat (cyc) begin
            @(negedge core_clk);
            hi += (reset_out_high !== 1'b0);
        end
    endtask

    task automatic t_power;
        repeat (8) @(negedge core_clk);
        `CHK("line_in_reset", 1'b0, reset_line_n)
        sys_rst = 1'b0;
        wait_rst(1'b0, n);
        in_range("power_release", n, RA, RA + 3);
        $display("test power done");
    endtask

    task automatic t_wdt;
        for (int c = 0; c < 3; c++) begin
            timeout_select = 2'(c);
            wait_rst(1'b1, n);
            wait_rst(1'b0, n);
            wait_rst(1'b1, n);
            in_range("wdt_period", n, P[c] - 2, P[c] + 2);
            `CHK("line_low", 1'b0, reset_line_n)
            wait_rst(1'b0, n);
            in_range("wdt_stretch", n, RA, RA + 3);
            `CHK("line_free", 1'b0, reset_out_low_n_oe)
        end
        $display("test watchdog done");
    endtask

    task automatic t_kick;
        timeout_select = 2'h0;
        kick_en = 1'b1;
        quiet(150, n);
        `CHK("kicked_hold", 0, n)
        $display("test kick done");
    endtask

    task automatic t_manual;
        manual_reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        manual_reset_n = 1'b1;
        quiet(20, n);
        `CHK("short_press", 0, n)
        manual_reset_n = 1'b0;
        wait_rst(1'b1, n);
        in_range("long_press", n, 6, 10);
        manual_reset_n = 1'b1;
        wait_rst(1'b0, n);
        in_range("press_stretch", n, RA, RA + 6);
        $display("test manual done");
    endtask

    task automatic t_supply;
        for (int t = 0; t < 2; t++) begin
            tolerance_select = t[0];
            {supply_below_10pct, supply_below_5pct} = t ? 2'h1 : 2'h2;
            quiet(20, n);
            `CHK("other_comp", 0, n)
            {supply_below_10pct, supply_below_5pct} = 2'h3;
            wait_rst(1'b1, n);
            in_range("uv_assert", n, 1, 4);
            repeat (40) @(negedge core_clk);
            `CHK("uv_hold", 1'b1, reset_out_high)
            {supply_below_10pct, supply_below_5pct} = 2'h0;
            wait_rst(1'b0, n);
            in_range("uv_release", n, RA, RA + 6);
        end
        $display("test supply done");
    endtask

    task automatic results;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        t_power();
        t_wdt();
        t_kick();
        t_manual();
        t_supply();
        results();
    end

    // whole sequence needs well under 3000 cycles
    initial begin
        #100000;
        n_fail++;
        results();
    end
endmodule
